// ---- ovs_supervisor.sv ----
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`default_nettype none
// Operation
// - Level held past timer triggers chosen action
// - Source select: 0 torque driving, 1 current
// - Level in percent of rated value
// - Mode 0 never takes any action
// - Mode 1 ramps down by deceleration time
// - Mode 2 cuts output, motor coasts
// - Mode 3 limited decel then holds torque
// - Alarm asserted while stopper action holds
// - Trip latched until run command cycles
// - Mode 3 overrides external torque limit
// - Gate: 0 const/decel, 1 const, 2 all
// - Modes 1 and 2 wait the timer, up to one tick short
// - Mode 3 acts immediately, ignores timer
module ovs_supervisor #(
	parameter int TICK_CYCLES = ovs_pkg::TICK_CYCLES
) (
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output var  logic [31:0]                 hrdata,
	output var  logic                        hreadyout,
	output var  logic                        hresp,
	input  wire logic                        run_cmd,
	input  wire logic [ovs_pkg::LOAD_W-1:0]  torque_drive_pct,
	input  wire logic [ovs_pkg::LOAD_W-1:0]  current_pct,
	input  wire logic                        accelerating,
	input  wire logic                        decelerating,
	output var  logic                        ramp_stop,
	output var  logic                        output_cutoff,
	output var  logic                        stopper_hold,
	output var  logic                        own_torque_limit,
	output var  logic                        accel_block,
	output var  logic                        overload_alarm_a,
	output var  logic                        overload_alarm_b,
	output var  logic                        irq
);
	import ovs_pkg::*;

	// Software view of the registers, one word each, fields in the low
	// bits and all other bits reading zero:
	//   config  source select, stop mode, detection gate;
	//   level   detection level in percent of the rated value;
	//   timer   persistence time in ticks of the prescaler;
	//   state   read only: trip, alarm, condition, run and trip mode;
	//   status  sticky events, trip and release, cleared by a one;
	//   mask    which status events raise the interrupt.
	// Unmapped words read zero and ignore writes, and the slave never
	// stretches a transfer, so every access takes two bus cycles.
	typedef struct packed {
		logic                load_source_select;
		ovs_mode_t           overload_stop_mode;
		ovs_gate_t           detect_state_gate;
		logic [LOAD_W-1:0]   overload_level_pct;
		logic [TMR_W-1:0]    overload_persist_timer;
		logic [7:0]          dp_addr;
		logic                dp_write;
		logic                dp_valid;
		logic                tripped;
		ovs_mode_t           trip_mode;
		logic [IRQ_W-1:0]    irq_status;
		logic [IRQ_W-1:0]    irq_mask;
		logic [31:0]         presc;
		logic                tick;
	} ovs_state_t;

	ovs_state_t st;
	ovs_state_t next_st;

	logic              run_level;
	logic [LOAD_W-1:0] load_now;
	logic              gate_ok;
	logic              over_level;
	logic              cond;
	logic              fire;
	logic              wr_hit;
	logic [IRQ_W-1:0]  irq_set;
	logic [31:0]       rd_word;

	ovs_tmr_if tmr_bus ();

	// The run command comes from a pin, so it passes the synchroniser
	// and is seen inside three to four cycles after it moves.
	ovs_sync u_run_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin     (run_cmd),
		.level   (run_level)
	);

	// The timer is cleared whenever the condition drops, and it reports
	// expiry one cycle after the count reaches the limit.
	ovs_persist_timer u_timer (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tmr     (tmr_bus.timer)
	);

	// Decides whether detection may run in the present speed state.
	// Gate code 3 is spare and reads as never detect, so a stray
	// code written by software cannot arm the stop by accident.
	function automatic logic gate_allows(input ovs_gate_t g,
		input logic acc, input logic dec);
		logic steady;
		steady = !acc && !dec;
		unique case (g)
			OVS_GATE_CONST_DEC: begin
				gate_allows = steady || dec;
			end
			OVS_GATE_CONST: begin
				gate_allows = steady;
			end
			OVS_GATE_ALL: begin
				gate_allows = 1'b1;
			end
			OVS_GATE_NONE: begin
				gate_allows = 1'b0;
			end
		endcase
	endfunction

	// Both quantities arrive already scaled to percent of motor rating.
	always_comb begin
		if (st.load_source_select == OVS_SRC_CURRENT) begin
			load_now = current_pct;
		end else begin
			load_now = torque_drive_pct;
		end
	end

	assign gate_ok = gate_allows(st.detect_state_gate,
		accelerating, decelerating);
	assign over_level = load_now > st.overload_level_pct;
	// Detection runs only while the synchronised run command is up and
	// no trip is latched, so a new trip needs the run command to go low
	// and high again first.
	assign cond = run_level && !st.tripped && gate_ok && over_level
		&& (st.overload_stop_mode != OVS_MODE_OFF);

	// Drops in load or gate restart the persistence count.
	assign tmr_bus.restart = !cond;
	assign tmr_bus.tick = st.tick;
	assign tmr_bus.limit = st.overload_persist_timer;

	// The stopper mode skips the timer: waiting would only let the
	// motor push against the stopper at full torque for longer.
	always_comb begin
		unique case (st.overload_stop_mode)
			OVS_MODE_STOPPER: begin
				fire = cond;
			end
			OVS_MODE_RAMP, OVS_MODE_COAST: begin
				fire = cond && tmr_bus.expired;
			end
			OVS_MODE_OFF: begin
				fire = 1'b0;
			end
		endcase
	end

	// Writes land at the end of the data phase, while hwdata stands.
	assign wr_hit = st.dp_valid && st.dp_write;

	// The release event lasts a single cycle, because the trip clears
	// on the edge after the synchronised run command is seen low.
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_TRIP_BIT] = fire;
		irq_set[IRQ_REL_BIT] = st.tripped && !run_level;
	end

	// The state word shows live detection, so software can watch a trip
	// building up before the timer runs out.
	always_comb begin
		rd_word = '0;
		unique case (st.dp_addr)
			ADDR_CONFIG: begin
				rd_word[CFG_SRC_BIT] = st.load_source_select;
				rd_word[CFG_MODE_LSB +: 2] = st.overload_stop_mode;
				rd_word[CFG_GATE_LSB +: 2] = st.detect_state_gate;
			end
			ADDR_LEVEL: begin
				rd_word[LOAD_W-1:0] = st.overload_level_pct;
			end
			ADDR_TIMER: begin
				rd_word[TMR_W-1:0] = st.overload_persist_timer;
			end
			ADDR_STATE: begin
				rd_word[ST_TRIP_BIT] = st.tripped;
				rd_word[ST_ALARM_BIT] = overload_alarm_a;
				rd_word[ST_COND_BIT] = cond;
				rd_word[ST_RUN_BIT] = run_level;
				rd_word[ST_MODE_LSB +: 2] = st.trip_mode;
			end
			ADDR_IRQ_STAT: begin
				rd_word[IRQ_W-1:0] = st.irq_status;
			end
			ADDR_IRQ_MASK: begin
				rd_word[IRQ_W-1:0] = st.irq_mask;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		// The tick prescaler runs free, so the first tick after the
		// condition appears may come early: the hold time is the set
		// count less up to one tick period.
		if (st.presc >= 32'(TICK_CYCLES - 1)) begin
			next_st.presc = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.presc = st.presc + 32'h0000_0001;
		end

		// Address phase capture; the slave never inserts wait states.
		if (hready) begin
			next_st.dp_valid = hsel && htrans[1];
			next_st.dp_write = hwrite;
			next_st.dp_addr = haddr[7:0];
		end

		if (wr_hit) begin
			unique case (st.dp_addr)
				ADDR_CONFIG: begin
					next_st.load_source_select = hwdata[CFG_SRC_BIT];
					next_st.overload_stop_mode =
						ovs_mode_t'(hwdata[CFG_MODE_LSB +: 2]);
					next_st.detect_state_gate =
						ovs_gate_t'(hwdata[CFG_GATE_LSB +: 2]);
				end
				ADDR_LEVEL: begin
					next_st.overload_level_pct = hwdata[LOAD_W-1:0];
				end
				ADDR_TIMER: begin
					next_st.overload_persist_timer = hwdata[TMR_W-1:0];
				end
				ADDR_IRQ_MASK: begin
					next_st.irq_mask = hwdata[IRQ_W-1:0];
				end
				default: ;
			endcase
		end

		// A fresh event in the clearing cycle survives the write of one.
		if (wr_hit && st.dp_addr == ADDR_IRQ_STAT) begin
			next_st.irq_status = (st.irq_status & ~hwdata[IRQ_W-1:0])
				| irq_set;
		end else begin
			next_st.irq_status = st.irq_status | irq_set;
		end

		// The action mode is frozen at the trip so that a later config
		// write cannot turn a coasting stop into a restart.
		if (st.tripped) begin
			if (!run_level) begin
				next_st.tripped = 1'b0;
				next_st.trip_mode = OVS_MODE_OFF;
			end
		end else if (fire) begin
			next_st.tripped = 1'b1;
			next_st.trip_mode = st.overload_stop_mode;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '{
				load_source_select:     OVS_SRC_TORQUE,
				overload_stop_mode:     OVS_MODE_OFF,
				detect_state_gate:      OVS_GATE_CONST_DEC,
				overload_level_pct:     LEVEL_RST,
				overload_persist_timer: TIMER_RST,
				dp_addr:                8'h00,
				dp_write:               1'b0,
				dp_valid:               1'b0,
				tripped:                1'b0,
				trip_mode:              OVS_MODE_OFF,
				irq_status:             '0,
				irq_mask:               '0,
				presc:                  32'h0000_0000,
				tick:                   1'b0
			};
		end else begin
			st <= next_st;
		end
	end

	// Read data is driven only in a read data phase, zero otherwise.
	always_comb begin
		hrdata = '0;
		if (st.dp_valid && !st.dp_write) begin
			hrdata = rd_word;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// The stop outputs stay up for as long as the trip is latched,
	// which also keeps the drive from accelerating again.
	always_comb begin
		ramp_stop = 1'b0;
		output_cutoff = 1'b0;
		stopper_hold = 1'b0;
		if (st.tripped) begin
			unique case (st.trip_mode)
				OVS_MODE_RAMP: begin
					ramp_stop = 1'b1;
				end
				OVS_MODE_COAST: begin
					output_cutoff = 1'b1;
				end
				OVS_MODE_STOPPER: begin
					// Holding torque ends with the run command, so the
					// brake must already be set by then.
					stopper_hold = 1'b1;
				end
				OVS_MODE_OFF: begin
					ramp_stop = 1'b0;
				end
			endcase
		end
	end

	// In stopper mode the block's own limit replaces any external
	// driving torque limit for as long as the hold lasts.
	assign own_torque_limit = stopper_hold;
	assign accel_block = st.tripped;
	assign overload_alarm_a = stopper_hold;
	assign overload_alarm_b = stopper_hold;
	assign irq = |(st.irq_status & st.irq_mask);
endmodule
`default_nettype wire

// ---- ovs_pkg.sv ----
`default_nettype none
package ovs_pkg;
	localparam int          DATA_W        = 32;
	localparam int          LOAD_W        = 16;
	localparam int          TMR_W         = 16;
	localparam int          CLK_HZ        = 20_000_000;
	localparam int          TICK_MS       = 10;
	localparam int          TICK_CYCLES   = TICK_MS * (CLK_HZ / 1000);

	localparam logic [7:0]  ADDR_CONFIG   = 8'h00;
	localparam logic [7:0]  ADDR_LEVEL    = 8'h04;
	localparam logic [7:0]  ADDR_TIMER    = 8'h08;
	localparam logic [7:0]  ADDR_STATE    = 8'h0c;
	localparam logic [7:0]  ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_MASK = 8'h14;

	localparam int          CFG_SRC_BIT   = 0;
	localparam int          CFG_MODE_LSB  = 1;
	localparam int          CFG_GATE_LSB  = 3;
	localparam int          ST_TRIP_BIT   = 0;
	localparam int          ST_ALARM_BIT  = 1;
	localparam int          ST_COND_BIT   = 2;
	localparam int          ST_RUN_BIT    = 3;
	localparam int          ST_MODE_LSB   = 4;
	localparam int          IRQ_TRIP_BIT  = 0;
	localparam int          IRQ_REL_BIT   = 1;
	localparam int          IRQ_W         = 2;

	localparam logic [LOAD_W-1:0] LEVEL_RST = 16'h0096;
	localparam logic [TMR_W-1:0]  TIMER_RST = 16'h0000;

	typedef enum logic [1:0] {
		OVS_MODE_OFF     = 2'b00,
		OVS_MODE_RAMP    = 2'b01,
		OVS_MODE_COAST   = 2'b10,
		OVS_MODE_STOPPER = 2'b11
	} ovs_mode_t;

	typedef enum logic [1:0] {
		OVS_GATE_CONST_DEC = 2'b00,
		OVS_GATE_CONST     = 2'b01,
		OVS_GATE_ALL       = 2'b10,
		OVS_GATE_NONE      = 2'b11
	} ovs_gate_t;

	localparam logic OVS_SRC_TORQUE  = 1'b0;
	localparam logic OVS_SRC_CURRENT = 1'b1;
endpackage
`default_nettype wire

// ---- ovs_tmr_if.sv ----
`default_nettype none
interface ovs_tmr_if;
	import ovs_pkg::*;
	logic              restart;
	logic              tick;
	logic [TMR_W-1:0]  limit;
	logic              expired;
	modport owner (output restart, output tick, output limit,
		input expired);
	modport timer (input restart, input tick, input limit,
		output expired);
endinterface
`default_nettype wire

// ---- ovs_sync.sv ----
`default_nettype none
module ovs_sync (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic pin,
	output var  logic level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} ovs_sync_t;

	ovs_sync_t st;
	ovs_sync_t next_st;

	// The filtered level moves only when the second and third stages agree.
	always_comb begin
		next_st = st;
		next_st.s1 = pin;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (st.s2 == st.s3) begin
			next_st.q = st.s3;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.q;
endmodule
`default_nettype wire

// ---- ovs_persist_timer.sv ----
`default_nettype none
module ovs_persist_timer (
	input  wire logic clk,
	input  wire logic sys_rst,
	ovs_tmr_if.timer  tmr
);
	import ovs_pkg::*;

	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic             done;
	} ovs_ptmr_t;

	ovs_ptmr_t st;
	ovs_ptmr_t next_st;

	always_comb begin
		next_st = st;
		if (tmr.restart) begin
			next_st.cnt  = '0;
			next_st.done = 1'b0;
		end else if (st.cnt >= tmr.limit) begin
			next_st.done = 1'b1;
		end else if (tmr.tick) begin
			next_st.cnt = st.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tmr.expired = st.done;
endmodule
`default_nettype wire

// ---- ovs_sva.sv ----
`default_nettype none
module ovs_sva (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic run_cmd,
	input wire logic ramp_stop,
	input wire logic output_cutoff,
	input wire logic stopper_hold,
	input wire logic own_torque_limit,
	input wire logic accel_block,
	input wire logic overload_alarm_a,
	input wire logic overload_alarm_b
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_bus; hreadyout && !hresp; endproperty
	a_bus: assert property (p_bus) else $error("bus answer not okay");
	property p_alarm_a; overload_alarm_a == stopper_hold; endproperty
	a_alarm_a: assert property (p_alarm_a)
		else $error("alarm a differs from hold");
	property p_alarm_b; overload_alarm_b == stopper_hold; endproperty
	a_alarm_b: assert property (p_alarm_b)
		else $error("alarm b differs from hold");
	property p_tlim; own_torque_limit == stopper_hold; endproperty
	a_tlim: assert property (p_tlim)
		else $error("own limit differs from hold");
	property p_block;
		(ramp_stop || output_cutoff || stopper_hold) |-> accel_block;
	endproperty
	a_block: assert property (p_block)
		else $error("trip without acceleration block");
	property p_excl; $onehot0({ramp_stop, output_cutoff, stopper_hold});
	endproperty
	a_excl: assert property (p_excl)
		else $error("more than one stop action");
	property p_hold; (accel_block && run_cmd) [*5] |=> accel_block;
	endproperty
	a_hold: assert property (p_hold)
		else $error("trip dropped while run held");
	property p_rel; (!run_cmd) [*8] |-> !accel_block; endproperty
	a_rel: assert property (p_rel)
		else $error("trip kept after run removed");
	property p_stay; $fell(run_cmd) && stopper_hold |=> stopper_hold;
	endproperty
	a_stay: assert property (p_stay)
		else $error("hold ended before run sync");
endmodule
bind ovs_supervisor ovs_sva u_ovs_sva (.*);
`default_nettype wire

// ---- ovs_drive_model.sv ----
`default_nettype none
module ovs_drive_model (
	input  wire logic        clk,
	input  wire logic        want_run,
	input  wire logic [15:0] tq_set,
	input  wire logic [15:0] cur_set,
	input  wire logic        acc_set,
	input  wire logic        dec_set,
	input  wire logic        stopper_hold,
	output var  logic        run_cmd,
	output var  logic [15:0] torque_drive_pct,
	output var  logic [15:0] current_pct,
	output var  logic        accelerating,
	output var  logic        decelerating,
	output var  logic        brake_on
);
	timeunit 1ns;
	timeprecision 1ns;
	initial brake_on = 1'b0;
	initial run_cmd = 1'b0;
	// The brake closes first, so run only drops a cycle after it.
	always @(posedge clk) begin
		brake_on <= !want_run && (brake_on || stopper_hold);
		run_cmd <= want_run || (stopper_hold && !brake_on);
		torque_drive_pct <= tq_set;
		current_pct <= cur_set;
		accelerating <= acc_set;
		decelerating <= dec_set;
	end
endmodule
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
module testbench import ovs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrd_q, hrdata;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	wire  logic  hready;
	logic        hreadyout, hresp, ramp_stop, output_cutoff, stopper_hold;
	logic        own_torque_limit, accel_block, irq, brake_on;
	logic        overload_alarm_a, overload_alarm_b;
	logic        run_cmd, accelerating, decelerating;
	logic [15:0] torque_drive_pct, current_pct;
	logic        want_run = 1'b0, acc_set = 1'b0, dec_set = 1'b0;
	logic [15:0] tq_set = 16'h0, cur_set = 16'h0;
	int          mismatches = 0, tests_run = 0;
	assign hready = hreadyout;
	ovs_supervisor #(.TICK_CYCLES(4)) u_ovs_supervisor (.*);
	ovs_drive_model u_ovs_drive_model (.*);
	always #25 clk = ~clk;
	always @(posedge clk) hrd_q <= hrdata;
	task automatic give_verdict;
		if (mismatches == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		#1 q = hrd_q;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, q, e);
	endtask
	task automatic drv(input logic r, input logic [15:0] t, c);
		@(posedge clk);
		want_run <= r;
		tq_set <= t;
		cur_set <= c;
	endtask
	function automatic logic [31:0] cfg(input logic s,
		input logic [1:0] m, g);
		return 32'(s) | (32'(m) << CFG_MODE_LSB) | (32'(g) << CFG_GATE_LSB);
	endfunction
	task automatic t_regs;
		rd(ADDR_CONFIG, 32'h0, "config");
		rd(ADDR_LEVEL, 32'(LEVEL_RST), "level");
		rd(ADDR_TIMER, 32'(TIMER_RST), "timer");
		rd(ADDR_IRQ_MASK, 32'h0, "mask");
		rd(8'h18, 32'h0, "unmapped");
		wr(ADDR_LEVEL, 32'h64);
		rd(ADDR_LEVEL, 32'h64, "level_wr");
	endtask
	task automatic t_off;
		wr(ADDR_CONFIG, cfg(OVS_SRC_TORQUE, OVS_MODE_OFF, OVS_GATE_ALL));
		drv(1'b1, 16'hc8, 16'hc8);
		cy(30);
		chk("off", accel_block, 1'b0);
		drv(1'b0, 16'h0, 16'h0);
		cy(10);
	endtask
	task automatic t_stop;
		wr(ADDR_TIMER, 32'h5);
		wr(ADDR_IRQ_MASK, 32'h1);
		wr(ADDR_CONFIG, cfg(OVS_SRC_TORQUE, OVS_MODE_STOPPER, OVS_GATE_ALL));
		drv(1'b1, 16'h64, 16'hc8);
		cy(20);
		chk("at_level", stopper_hold, 1'b0);
		drv(1'b1, 16'h65, 16'h0);
		cy(4);
		chk("hold", stopper_hold, 1'b1);
		chk("alarm", {overload_alarm_a, overload_alarm_b}, 2'h3);
		chk("tlim", own_torque_limit, 1'b1);
		chk("irq", irq, 1'b1);
		rd(ADDR_STATE, (32'h1 << ST_TRIP_BIT) | (32'h1 << ST_ALARM_BIT)
			| (32'h1 << ST_RUN_BIT) | (32'h3 << ST_MODE_LSB), "state");
		drv(1'b1, 16'h0, 16'h0);
		wr(ADDR_CONFIG, cfg(OVS_SRC_TORQUE, OVS_MODE_RAMP, OVS_GATE_ALL));
		cy(5);
		chk("latched", {ramp_stop, stopper_hold, accel_block}, 3'h3);
		wr(ADDR_IRQ_STAT, 32'h1);
		cy(1);
		chk("irq_clr", irq, 1'b0);
		drv(1'b0, 16'h0, 16'h0);
		cy(10);
		chk("brake", brake_on, 1'b1);
		chk("released", accel_block, 1'b0);
		rd(ADDR_IRQ_STAT, 32'h1 << IRQ_REL_BIT, "release_event");
	endtask
	task automatic t_persist;
		wr(ADDR_TIMER, 32'h4);
		wr(ADDR_CONFIG, cfg(OVS_SRC_CURRENT, OVS_MODE_RAMP, OVS_GATE_ALL));
		drv(1'b1, 16'hc8, 16'h32);
		cy(30);
		chk("src_cur", ramp_stop, 1'b0);
		drv(1'b1, 16'h0, 16'hc8);
		cy(11);
		chk("early", ramp_stop, 1'b0);
		drv(1'b1, 16'h0, 16'h32);
		cy(2);
		drv(1'b1, 16'h0, 16'hc8);
		cy(11);
		chk("restart", ramp_stop, 1'b0);
		cy(20);
		chk("ramp", {ramp_stop, output_cutoff, accel_block}, 3'h5);
		drv(1'b0, 16'h0, 16'h0);
		cy(10);
	endtask
	task automatic t_gate;
		// Bit 3*gate+state: states are constant, accelerating, decelerating.
		// Gate code 3 never detects.
		logic [11:0] exp;
		exp = 12'h1cd;
		wr(ADDR_TIMER, 32'h0);
		for (int g = 0; g < 4; g++) begin
			for (int s = 0; s < 3; s++) begin
				wr(ADDR_CONFIG, cfg(OVS_SRC_TORQUE, OVS_MODE_COAST, 2'(g)));
				@(posedge clk);
				acc_set <= (s == 1);
				dec_set <= (s == 2);
				drv(1'b1, 16'hc8, 16'h0);
				cy(12);
				chk("gate", output_cutoff, exp[g*3+s]);
				drv(1'b0, 16'h0, 16'h0);
				cy(10);
			end
		end
	endtask
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs;
		t_off;
		t_stop;
		t_persist;
		t_gate;
		give_verdict;
	end
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		give_verdict;
	end
endmodule
`default_nettype wire
